/* rtl/isi_pkg.sv */
// Purpose: constants shared by the interrupt source identity block
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes: identity words have no defined reset content; zero is used
package isi_pkg;

    // byte offsets of the per-line source identity words
    localparam logic [11:0] ISI_OFS_BROWNOUT = 12'h000;
    localparam logic [11:0] ISI_OFS_WATCHDOG = 12'h004;
    localparam logic [11:0] ISI_OFS_EXT_A = 12'h008;
    localparam logic [11:0] ISI_OFS_EXT_B = 12'h00c;
    localparam logic [11:0] ISI_OFS_GPIO = 12'h010;
    localparam logic [11:0] ISI_OFS_LEVEL = 12'h014;
    localparam logic [11:0] ISI_OFS_PULSE = 12'h018;

    // sticky event status (read clears) and its mask
    localparam logic [11:0] ISI_OFS_STATUS = 12'h100;
    localparam logic [11:0] ISI_OFS_MASK = 12'h104;

    // number of request inputs, one status bit each
    localparam int ISI_NUM_SRC = 8;

    // positions of each request in the status and mask layout
    localparam int ISI_POS_BROWNOUT = 0;
    localparam int ISI_POS_WATCHDOG = 1;
    localparam int ISI_POS_EXT_FIRST = 2;
    localparam int ISI_POS_EXT_SECOND = 3;
    localparam int ISI_POS_PORT_A = 4;
    localparam int ISI_POS_PORT_B = 5;
    localparam int ISI_POS_LEVEL = 6;
    localparam int ISI_POS_PULSE = 7;

    // field of the identity word that carries source_flags
    localparam int ISI_FLAGS_LSB = 0;
    localparam int ISI_FLAGS_W = 3;

    // values after reset
    localparam logic [7:0] ISI_SRC_RST = 8'h00;
    localparam logic [7:0] ISI_STATUS_RST = 8'h00;
    localparam logic [7:0] ISI_MASK_RST = 8'h00;
    localparam logic [31:0] ISI_RDATA_RST = 32'h0000_0000;

endpackage : isi_pkg

/* rtl/isi_regs.sv */
// Purpose: read-only interrupt source identity words for lines 0 to 6,
//          plus a sticky event status, mask and one interrupt output
// Assumes: request inputs come from logic clocked by hclk
// Notes: zero wait state AHB-Lite slave, always answers OKAY
module isi_regs (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic brownout_request,
    input wire logic watchdog_request,
    input wire logic ext_pin_first_request,
    input wire logic ext_pin_second_request,
    input wire logic port_a_request,
    input wire logic port_b_request,
    input wire logic level_control_request,
    input wire logic pulse_width_request,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////
    // declarations

    localparam int NS = isi_pkg::ISI_NUM_SRC;

    logic [NS-1:0] src_now;
    logic [NS-1:0] src_d, src_q;
    logic [NS-1:0] rise;
    logic [NS-1:0] status_d, status_q;
    logic [NS-1:0] mask_d, mask_q;
    logic [NS-1:0] stat_clr;
    logic wr_pend_d, wr_pend_q;
    logic [31:0] hrdata_d, hrdata_q;
    logic irq_d, irq_q;
    logic rd_acc;
    logic wr_acc;
    logic [11:0] word_addr;
    logic [31:0] rd_word;

    // identity word: source_flags in the low bits, reserved read zero
    function automatic logic [31:0] isi_word(input logic b1,
                                             input logic b0);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[isi_pkg::ISI_FLAGS_LSB +: isi_pkg::ISI_FLAGS_W] = {1'b0, b1, b0};
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // request gathering

    // one vector, laid out as status and mask
    always_comb begin
        src_now = '0;
        src_now[isi_pkg::ISI_POS_BROWNOUT] = brownout_request;
        src_now[isi_pkg::ISI_POS_WATCHDOG] = watchdog_request;
        src_now[isi_pkg::ISI_POS_EXT_FIRST] = ext_pin_first_request;
        src_now[isi_pkg::ISI_POS_EXT_SECOND] = ext_pin_second_request;
        src_now[isi_pkg::ISI_POS_PORT_A] = port_a_request;
        src_now[isi_pkg::ISI_POS_PORT_B] = port_b_request;
        src_now[isi_pkg::ISI_POS_LEVEL] = level_control_request;
        src_now[isi_pkg::ISI_POS_PULSE] = pulse_width_request;
    end

    ////////////////////////////////////////////////////////////////////
    // bus decode

    // only NONSEQ/SEQ with hready high start a transfer
    always_comb begin
        rd_acc = hsel && hready && htrans[1] && !hwrite;
        wr_acc = hsel && hready && htrans[1] && hwrite;
        word_addr = {haddr[11:2], 2'b00}; // hsize ignored: words only
    end

    ////////////////////////////////////////////////////////////////////
    // read mux

    // a mask write still in its data phase is forwarded to the read
    always_comb begin
        case (word_addr)
            isi_pkg::ISI_OFS_BROWNOUT:
                rd_word = isi_word(1'b0,
                    src_q[isi_pkg::ISI_POS_BROWNOUT]);
            isi_pkg::ISI_OFS_WATCHDOG:
                rd_word = isi_word(1'b0,
                    src_q[isi_pkg::ISI_POS_WATCHDOG]);
            isi_pkg::ISI_OFS_EXT_A:
                rd_word = isi_word(1'b0,
                    src_q[isi_pkg::ISI_POS_EXT_FIRST]);
            isi_pkg::ISI_OFS_EXT_B:
                rd_word = isi_word(1'b0,
                    src_q[isi_pkg::ISI_POS_EXT_SECOND]);
            isi_pkg::ISI_OFS_GPIO:
                rd_word = isi_word(src_q[isi_pkg::ISI_POS_PORT_B],
                    src_q[isi_pkg::ISI_POS_PORT_A]);
            isi_pkg::ISI_OFS_LEVEL:
                rd_word = isi_word(1'b0,
                    src_q[isi_pkg::ISI_POS_LEVEL]);
            isi_pkg::ISI_OFS_PULSE:
                rd_word = isi_word(1'b0,
                    src_q[isi_pkg::ISI_POS_PULSE]);
            isi_pkg::ISI_OFS_STATUS:
                rd_word = {{(32-NS){1'b0}}, status_q};
            isi_pkg::ISI_OFS_MASK:
                rd_word = {{(32-NS){1'b0}}, mask_d};
            default:
                rd_word = 32'h0000_0000; // unmapped reads as zero
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // next state

    // set wins over the read clear, so no edge is lost
    always_comb begin
        src_d = src_now;
        rise = src_now & ~src_q;
        stat_clr = '0;
        if (rd_acc && word_addr == isi_pkg::ISI_OFS_STATUS) begin
            stat_clr = status_q;
        end
        status_d = (status_q & ~stat_clr) | rise;
        // only the mask is writable; identity writes fall through
        wr_pend_d = wr_acc && word_addr == isi_pkg::ISI_OFS_MASK;
        mask_d = wr_pend_q ? hwdata[NS-1:0] : mask_q;
        hrdata_d = rd_acc ? rd_word : isi_pkg::ISI_RDATA_RST;
        irq_d = |(status_d & mask_d);
    end

    ////////////////////////////////////////////////////////////////////
    // registers

    // identity reset value is undefined; zero keeps sims clean
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_q <= isi_pkg::ISI_SRC_RST;
            status_q <= isi_pkg::ISI_STATUS_RST;
            mask_q <= isi_pkg::ISI_MASK_RST;
            wr_pend_q <= 1'b0;
            hrdata_q <= isi_pkg::ISI_RDATA_RST;
            irq_q <= 1'b0;
        end else begin
            src_q <= src_d;
            status_q <= status_d;
            mask_q <= mask_d;
            wr_pend_q <= wr_pend_d;
            hrdata_q <= hrdata_d;
            irq_q <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    // never stalls and never errors, so ready and resp are constants
    // held in flops to keep every output registered
    logic ready_q;
    logic resp_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ready_q <= 1'b1;
            resp_q <= 1'b0;
        end else begin
            ready_q <= 1'b1;
            resp_q <= 1'b0; // OKAY only: nothing here can fail
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = ready_q;
    assign hresp = resp_q;
    assign irq = irq_q;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_read(logic [11:0] ofs);
        rd_acc && word_addr == ofs;
    endsequence

    sequence s_any_ident;
        rd_acc && word_addr <= isi_pkg::ISI_OFS_PULSE;
    endsequence

    // status read: returns the word and clears it at the address edge
    sequence s_status_read;
        rd_acc && word_addr == isi_pkg::ISI_OFS_STATUS;
    endsequence

    // mask write: address phase, then the edge that takes hwdata
    sequence s_mask_write;
        wr_acc && word_addr == isi_pkg::ISI_OFS_MASK ##1 1'b1;
    endsequence

    a_reserved_zero: assert property (
        s_any_ident |=> hrdata_q[31:3] == 29'h0 && hrdata_q[2] == 1'b0)
        else $error("identity word reserved bits not zero");

    a_line0_word: assert property (
        s_read(isi_pkg::ISI_OFS_BROWNOUT) |=>
            hrdata_q == {31'h0, $past(brownout_request, 2)})
        else $error("line 0 word does not match brownout");

    a_line1_word: assert property (
        s_read(isi_pkg::ISI_OFS_WATCHDOG) |=>
            hrdata_q == {31'h0, $past(watchdog_request, 2)})
        else $error("line 1 word does not match watchdog");

    a_line2_word: assert property (
        s_read(isi_pkg::ISI_OFS_EXT_A) |=>
            hrdata_q == {31'h0, $past(ext_pin_first_request, 2)})
        else $error("line 2 word does not match first pin");

    a_line3_word: assert property (
        s_read(isi_pkg::ISI_OFS_EXT_B) |=>
            hrdata_q == {31'h0, $past(ext_pin_second_request, 2)})
        else $error("line 3 word does not match second pin");

    a_line4_word: assert property (
        s_read(isi_pkg::ISI_OFS_GPIO) |=>
            hrdata_q == {30'h0, $past(port_b_request, 2),
                         $past(port_a_request, 2)})
        else $error("line 4 word does not match port pair");

    a_line5_word: assert property (
        s_read(isi_pkg::ISI_OFS_LEVEL) |=>
            hrdata_q == {31'h0, $past(level_control_request, 2)})
        else $error("line 5 word does not match level control");

    a_line6_word: assert property (
        s_read(isi_pkg::ISI_OFS_PULSE) |=>
            hrdata_q == {31'h0, $past(pulse_width_request, 2)})
        else $error("line 6 word does not match pulse width");

    // an identity access may add edges to status but never clears it;
    // the mask could only move at the edge that ends the data phase
    a_ident_no_effect: assert property (
        (rd_acc || wr_acc) && word_addr <= isi_pkg::ISI_OFS_PULSE
            |=> (status_q & $past(status_q)) == $past(status_q)
                ##1 $stable(mask_q))
        else $error("identity access changed status or mask");

    a_bus_always_ok: assert property (
        hreadyout && !hresp)
        else $error("slave stalled or answered error");

    a_irq_follows: assert property (
        ##1 irq_q == |(status_q & mask_q))
        else $error("interrupt output disagrees with status");

    ////////////////////////////////////////////////////////////////////
    // event status, mask and read data checks

    // a request edge always lands in status, even during a clearing read
    a_edge_sets: assert property (
        1'b1 |=> (status_q & $past(src_now) & ~$past(src_now, 2))
            == ($past(src_now) & ~$past(src_now, 2)))
        else $error("request edge did not set its status bit");

    // status bits never appear without a request edge behind them
    a_no_false_set: assert property (
        1'b1 |=> (status_q & ~$past(status_q)
            & ~($past(src_now) & ~$past(src_now, 2))) == {NS{1'b0}})
        else $error("status bit set without a request edge");

    // the word is the status seen at the address edge
    a_status_word: assert property (
        s_status_read |=> hrdata_q == {{(32-NS){1'b0}}, $past(status_q)})
        else $error("status read returned wrong word");

    // only an edge in the same cycle survives the clearing read
    a_status_clear: assert property (
        s_status_read |=>
            status_q == ($past(src_now) & ~$past(src_now, 2)))
        else $error("status read did not clear returned bits");

    // takes hwdata at the end of the data phase
    a_mask_write: assert property (
        s_mask_write |=> mask_q == $past(hwdata[NS-1:0]))
        else $error("mask write did not land");

    a_mask_upper_zero: assert property (
        s_read(isi_pkg::ISI_OFS_MASK) |=> hrdata_q[31:NS] == '0)
        else $error("mask word upper bits not zero");

    // hrdata drops to zero between reads, never stale
    a_rdata_idle: assert property (
        !rd_acc |=> hrdata_q == 32'h0000_0000)
        else $error("read data not zero outside a read");

    // with all sources masked the level must stay low
    a_irq_masked: assert property (
        mask_q == {NS{1'b0}} |-> !irq_q)
        else $error("interrupt raised with every source masked");

endmodule // isi_regs

/* dv/isi_req_model.sv */
// Purpose: peripheral side, holds the eight request levels
// Assumes: new levels loaded after a rising edge of hclk
// Notes: levels only move when the bench loads them
module isi_req_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic upd,
    input wire logic [7:0] upd_val,
    output logic [7:0] req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] req_q;
    logic [7:0] req_d;

    ////////////////////////////////////////////////////////////////////
    // levels held between loads so reads see a stable source
    always_comb begin
        req_d = upd ? upd_val : req_q;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_q <= 8'h00;
        end else begin
            req_q <= req_d;
        end
    end

    assign req = req_q;
endmodule // isi_req_model

/* dv/testbench.sv */
// Purpose: self-checking bench for the source identity words
// Assumes: zero wait state slave, single word transfers
// Notes: expected status tracked from request rising edges
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, upd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0] req, upd_val, req_cur, st_exp, mask_exp;
    logic [11:0] ofs [7];
    int n_fail, n_compared, cycles, seed;

    isi_req_model i_isi_req_model (.hclk(hclk), .hresetn(hresetn),
        .upd(upd), .upd_val(upd_val), .req(req));
    isi_regs i_isi_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .brownout_request(req[0]), .watchdog_request(req[1]),
        .ext_pin_first_request(req[2]), .ext_pin_second_request(req[3]),
        .port_a_request(req[4]), .port_b_request(req[5]),
        .level_control_request(req[6]), .pulse_width_request(req[7]),
        .irq(irq));

    always #5 hclk = ~hclk;

    ////////////////////////////////////////////////////////////////////
    // hang guard, far above the expected run length
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cmp_word(logic [31:0] got, logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask

    // single-bit levels: interrupt line and bus response
    task automatic cmp_level(logic got, logic exp);
        n_compared++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    // bus cycles; only the hang guard ends a wait that never completes
    task automatic wait_ready();
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
    endtask

    task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h00000, a};
        htrans <= 2'b10;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
        cmp_level(hresp, 1'b0);
    endtask

    // irq checked two edges after the load, once status settled
    task automatic set_req(logic [7:0] v);
        @(posedge hclk);
        upd <= 1'b1;
        upd_val <= v;
        @(posedge hclk);
        upd <= 1'b0;
        st_exp |= v & ~req_cur;
        req_cur = v;
        repeat (2) @(posedge hclk);
        cmp_level(irq, |(st_exp & mask_exp));
    endtask

    function automatic logic [31:0] exp_ident(int ln, logic [7:0] r);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (ln)
            4: begin
                w[0] = r[isi_pkg::ISI_POS_PORT_A];
                w[1] = r[isi_pkg::ISI_POS_PORT_B];
            end
            5: w[0] = r[isi_pkg::ISI_POS_LEVEL];
            6: w[0] = r[isi_pkg::ISI_POS_PULSE];
            default: w[0] = r[ln];
        endcase
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // main sequence: reset, random levels, writes, unmapped, irq
    initial begin
        {hclk, hresetn, hsel, hwrite, upd} = 5'b00000;
        {htrans, hsize, haddr, hwdata} = {2'b00, 3'h2, 64'h0};
        {upd_val, req_cur, st_exp, mask_exp} = 32'h0;
        ofs = '{isi_pkg::ISI_OFS_BROWNOUT, isi_pkg::ISI_OFS_WATCHDOG,
            isi_pkg::ISI_OFS_EXT_A, isi_pkg::ISI_OFS_EXT_B,
            isi_pkg::ISI_OFS_GPIO, isi_pkg::ISI_OFS_LEVEL,
            isi_pkg::ISI_OFS_PULSE};
        seed = 1;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, isi_pkg::ISI_OFS_MASK, 32'h0);
        cmp_word(rd, 32'h0);
        // corner: every source at once, then all released, all masked
        set_req(8'hff);
        set_req(8'h00);
        for (int it = 0; it < 40; it++) begin
            if (it % 10 == 0) begin
                mask_exp = 8'($random(seed));
                xfer(1'b1, isi_pkg::ISI_OFS_MASK, {24'h0, mask_exp});
            end
            set_req(8'($random(seed)));
            for (int ln = 0; ln < 7; ln++) begin
                if (it % 8 == 1)
                    xfer(1'b1, ofs[ln], 32'hffff_ffff);
                xfer(1'b0, ofs[ln], 32'h0);
                case (ln)
                    0: cmp_word(rd, exp_ident(ln, req_cur));
                    1: cmp_word(rd, exp_ident(ln, req_cur));
                    2: cmp_word(rd, exp_ident(ln, req_cur));
                    3: cmp_word(rd, exp_ident(ln, req_cur));
                    4: cmp_word(rd, exp_ident(ln, req_cur));
                    5: cmp_word(rd, exp_ident(ln, req_cur));
                    default: cmp_word(rd, exp_ident(ln, req_cur));
                endcase
            end
            if (it % 4 == 3) begin
                xfer(1'b0, isi_pkg::ISI_OFS_STATUS, 32'h0);
                cmp_word(rd, {24'h0, st_exp});
                st_exp = 8'h00;
                xfer(1'b0, isi_pkg::ISI_OFS_STATUS, 32'h0);
                cmp_word(rd, 32'h0);
            end
        end
        xfer(1'b0, 12'h01c, 32'h0);
        cmp_word(rd, 32'h0);
        complete_run();
    end
endmodule // testbench
